/* File: verilog/trip_floor_pkg.sv */
// shared constants and types for the delayed trip / floor voltage sequencer
package trip_floor_pkg;
    localparam int NUM_CH         = 8;
    localparam int VOLT_W         = 16;
    localparam int PCT_W          = 7;
    localparam int DELAY_W        = 12;
    localparam int MS_W           = 9;
    // tick timing: clock rate and tick period in their own units
    localparam int CLK_FREQ_KHZ   = 20000;
    localparam int TICK_PERIOD_MS = 1;
    localparam int TICK_CYCLES    = CLK_FREQ_KHZ * TICK_PERIOD_MS;
    // trip delay limit and measurement time, both in ms ticks
    localparam logic [DELAY_W-1:0] MAX_DELAY_MS = 12'hFA0;
    localparam logic [MS_W-1:0]    VMEAS_TIME_MS = 9'h1F4;
    localparam logic [PCT_W-1:0]   PCT_FULL     = 7'h64;
    // headroom added above the measured voltage when lowering the setpoint
    localparam logic [VOLT_W-1:0]  VMEAS_MARGIN = 16'h0010;
    localparam logic [VOLT_W-1:0]  VOLT_RST     = 16'h0000;

    typedef logic [VOLT_W-1:0] volt_t;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_LIMIT,
        ST_FLOOR_HOLD,
        ST_RECOVER,
        ST_TRIPPED
    } chan_state_e;
endpackage : trip_floor_pkg

/* File: verilog/setpoint_ramp_if.sv */
// link between a channel's sequencer and its setpoint ramp generator
interface setpoint_ramp_if;
    import trip_floor_pkg::*;
    volt_t target;
    volt_t step;
    logic  jump;
    volt_t jump_value;
    volt_t value;
    logic  at_target;

    modport seq_side (
        output target, step, jump, jump_value,
        input  value, at_target
    );
    modport ramp_side (
        input  target, step, jump, jump_value,
        output value, at_target
    );
endinterface : setpoint_ramp_if

/* File: verilog/ms_tick_gen.sv */
// one-cycle pulse every millisecond
module ms_tick_gen #(
    parameter int TICK_CYCLES = 20000
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    output logic      tick
);
    logic [31:0] cnt_ff;
    logic        tick_ff;
    wire         wrap = (cnt_ff == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= wrap ? 32'h0 : cnt_ff + 32'h1;
            tick_ff <= wrap;
        end
    end

    assign tick = tick_ff;
endmodule : ms_tick_gen

/* File: verilog/setpoint_ramp.sv */
// internal setpoint register: jumps on request, else ramps once per tick
module setpoint_ramp (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic         tick,
    setpoint_ramp_if.ramp_side rp
);
    import trip_floor_pkg::*;
    volt_t val_ff;
    volt_t nxt_val;
    wire   up       = rp.target > val_ff;
    wire   big_gap  = up ? (rp.target - val_ff) > rp.step
                         : (val_ff - rp.target) > rp.step;
    wire   volt_t up_val = big_gap ? val_ff + rp.step : rp.target;
    wire   volt_t dn_val = big_gap ? val_ff - rp.step : rp.target;

    always_comb begin
        nxt_val = val_ff;
        if (rp.jump) begin
            nxt_val = rp.jump_value;
        end else if (tick) begin
            nxt_val = up ? up_val : dn_val;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            val_ff <= VOLT_RST;
        end else begin
            val_ff <= nxt_val;
        end
    end

    assign rp.value     = val_ff;
    assign rp.at_target = (val_ff == rp.target);
endmodule : setpoint_ramp

/* File: verilog/delayed_trip_floor_voltage_ctrl.sv */
// per-channel delayed trip and floor voltage sequencer
// Behaviour
// - per-channel trip delay in 1 ms steps, at most four seconds
// - current stays clamped at its setpoint while the delay runs
// - regulation status of each channel sampled once per ms tick
// - each tick in current-limit regulation decrements the delay counter
// - back in voltage regulation before expiry: counter reloaded to full once vset is reached again
// - new measured voltage in current limit: setpoint lowered just above it
// - lowered setpoint ramps back; counter reloaded only on reaching setpoint
// - per-channel floor voltage as 0 to 100 percent of programmed setpoint
// - entering current limit from NORMAL drops setpoint to the floor at once
// - 0 percent floor shuts down; 100 percent leaves setpoint unreduced
// - channel held at floor until software clears event, then ramps back
// - discharge ends above floor: channel stays at floor until cleared
// - long current limit: setpoint lowered, ramps back up to floor
// - still limiting at expiry: whole group ramps down, trip event raised
// - tripped channel ramps down from the already lowered setpoint
// - fast overcurrent shutdown enabled disables the trip delay
// - new measured voltage counted valid only after measurement time
module delayed_trip_floor_voltage_ctrl
    import trip_floor_pkg::*;
#(
    parameter int TICK_CYCLES_P = trip_floor_pkg::TICK_CYCLES
) (
    input  wire logic                                 clk_sys,
    input  wire logic                                 srst,
    input  wire logic [trip_floor_pkg::NUM_CH-1:0]    voltage_regulation,
    input  wire logic [trip_floor_pkg::NUM_CH-1:0]    current_limit_regulation,
    input  wire trip_floor_pkg::volt_t                vmeas [trip_floor_pkg::NUM_CH],
    input  wire logic [trip_floor_pkg::NUM_CH-1:0]    vmeas_valid,
    input  wire trip_floor_pkg::volt_t                vset [trip_floor_pkg::NUM_CH],
    input  wire trip_floor_pkg::volt_t                ramp_step [trip_floor_pkg::NUM_CH],
    input  wire logic [trip_floor_pkg::DELAY_W-1:0]   trip_delay_ms [trip_floor_pkg::NUM_CH],
    input  wire logic [trip_floor_pkg::PCT_W-1:0]     floor_pct [trip_floor_pkg::NUM_CH],
    input  wire logic [trip_floor_pkg::NUM_CH-1:0]    fast_overcurrent_shutdown,
    input  wire logic [trip_floor_pkg::NUM_CH-1:0]    floor_event_clear,
    input  wire logic                                 trip_event_clear,
    output trip_floor_pkg::volt_t                     vsetint [trip_floor_pkg::NUM_CH],
    output logic [trip_floor_pkg::NUM_CH-1:0]         current_clamp,
    output logic [trip_floor_pkg::NUM_CH-1:0]         floor_reached_event,
    output logic                                      trip_event
);
    import trip_floor_pkg::*;

    logic              tick;
    logic [NUM_CH-1:0] cv_meta_ff;
    logic [NUM_CH-1:0] cv_ff;
    logic [NUM_CH-1:0] cc_meta_ff;
    logic [NUM_CH-1:0] cc_ff;
    logic [NUM_CH-1:0] trip_req;
    logic [NUM_CH-1:0] clamp_ff;
    logic [NUM_CH-1:0] floor_ev_ff;
    logic              trip_ev_ff;
    wire               group_trip = |trip_req;

    ms_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES_P)
    ) u_tick (
        .clk_sys (clk_sys),
        .srst    (srst),
        .tick    (tick)
    );

    // status pins are asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cv_meta_ff <= '0;
            cv_ff      <= '0;
            cc_meta_ff <= '0;
            cc_ff      <= '0;
        end else begin
            cv_meta_ff <= voltage_regulation;
            cv_ff      <= cv_meta_ff;
            cc_meta_ff <= current_limit_regulation;
            cc_ff      <= cc_meta_ff;
        end
    end

    // trip event: a new trip wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            trip_ev_ff <= 1'b0;
        end else if (group_trip) begin
            trip_ev_ff <= 1'b1;
        end else if (trip_event_clear) begin
            trip_ev_ff <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            setpoint_ramp_if rp ();
            chan_state_e            st_ff;
            chan_state_e            nxt_st;
            logic [DELAY_W-1:0]     cnt_ff;
            logic [DELAY_W-1:0]     nxt_cnt;
            logic [MS_W-1:0]        ccms_ff;
            logic [MS_W-1:0]        nxt_ccms;
            volt_t                  tgt_ff;
            volt_t                  nxt_tgt;
            logic                   vm_new_ff;
            logic                   vm_used;
            logic                   floor_set;
            logic                   jump;
            volt_t                  jump_val;

            // delay above four seconds is clamped, zero treated as 1 ms
            wire [DELAY_W-1:0] dly_big  = trip_delay_ms[gi] > MAX_DELAY_MS
                                          ? MAX_DELAY_MS : trip_delay_ms[gi];
            wire [DELAY_W-1:0] dly_lim  = (dly_big == '0) ? 12'h001
                                          : dly_big;
            wire [PCT_W-1:0]   pct_lim  = floor_pct[gi] > PCT_FULL
                                          ? PCT_FULL : floor_pct[gi];
            wire [31:0]        floor_w  = (32'(vset[gi]) * 32'(pct_lim))
                                          / 32'(PCT_FULL);
            wire volt_t        floor_v  = floor_w[VOLT_W-1:0];
            wire               use_fl   = (pct_lim != PCT_FULL);
            wire               cc_tick  = tick & cc_ff[gi];
            wire               cv_tick  = tick & cv_ff[gi] & ~cc_ff[gi];
            wire               dt_on    = ~fast_overcurrent_shutdown[gi];
            wire               in_limit = (st_ff == ST_LIMIT);
            // saturate so a reading near full scale cannot wrap to a tiny value
            wire [VOLT_W:0]    vm_sum   = {1'b0, vmeas[gi]}
                                          + {1'b0, VMEAS_MARGIN};
            wire volt_t        vm_above = vm_sum[VOLT_W] ? '1
                                          : vm_sum[VOLT_W-1:0];
            // measured value usable once it is fresh and settled
            wire               vm_ok    = vm_new_ff
                                          & (ccms_ff >= VMEAS_TIME_MS);
            wire               lower_ok = vm_ok
                                          & (vm_above < rp.value);

            // NORMAL still holds the reload, so a 1 ms delay trips on the
            // very tick that enters current limit
            wire [DELAY_W-1:0] cnt_now  = (st_ff == ST_NORMAL) ? dly_lim
                                          : cnt_ff;
            // a tripped group ignores current limit until it is released
            wire               cnt_arm  = (st_ff != ST_TRIPPED);

            assign trip_req[gi] = cnt_arm & cc_tick & dt_on
                                  & (cnt_now <= 12'h001);

            always_comb begin
                nxt_st    = st_ff;
                nxt_cnt   = cnt_ff;
                nxt_ccms  = ccms_ff;
                nxt_tgt   = tgt_ff;
                jump      = 1'b0;
                jump_val  = rp.value;
                floor_set = 1'b0;
                vm_used   = 1'b0;
                case (st_ff)
                    ST_NORMAL: begin
                        nxt_tgt = vset[gi];
                        nxt_cnt = dly_lim;
                        if (cc_tick && dt_on) begin
                            nxt_st   = ST_LIMIT;
                            nxt_cnt  = dly_lim - 12'h001;
                            nxt_ccms = 9'h001;
                            if (use_fl) begin
                                jump      = 1'b1;
                                jump_val  = floor_v;
                                nxt_tgt   = floor_v;
                                floor_set = 1'b1;
                            end
                        end
                    end
                    ST_LIMIT: begin
                        if (!dt_on) begin
                            nxt_st  = ST_NORMAL;
                            nxt_tgt = vset[gi];
                        end else if (cc_tick) begin
                            nxt_cnt  = cnt_ff - 12'h001;
                            if (ccms_ff != '1) begin
                                nxt_ccms = ccms_ff + 9'h001;
                            end
                            if (lower_ok) begin
                                jump     = 1'b1;
                                jump_val = vm_above;
                                // hold there: no climb while still limiting
                                nxt_tgt  = vm_above;
                                vm_used  = 1'b1;
                            end
                        end else if (cv_tick) begin
                            nxt_ccms = '0;
                            if (floor_ev_ff[gi] && use_fl) begin
                                nxt_st  = ST_FLOOR_HOLD;
                                nxt_tgt = floor_v;
                            end else begin
                                nxt_st  = ST_RECOVER;
                                nxt_tgt = vset[gi];
                            end
                        end
                    end
                    ST_FLOOR_HOLD: begin
                        nxt_tgt = floor_v;
                        // re-entry keeps counting; only reaching vset reloads
                        if (cc_tick && dt_on) begin
                            nxt_st   = ST_LIMIT;
                            nxt_cnt  = cnt_ff - 12'h001;
                            nxt_ccms = 9'h001;
                        end else if (!floor_ev_ff[gi]) begin
                            nxt_st  = ST_RECOVER;
                            nxt_tgt = vset[gi];
                        end
                    end
                    ST_RECOVER: begin
                        nxt_tgt = vset[gi];
                        if (cc_tick && dt_on) begin
                            nxt_st   = ST_LIMIT;
                            nxt_cnt  = cnt_ff - 12'h001;
                            nxt_ccms = 9'h001;
                        end else if (rp.at_target) begin
                            nxt_st  = ST_NORMAL;
                            nxt_cnt = dly_lim;
                        end
                    end
                    ST_TRIPPED: begin
                        // current limit ignored here; only a clear releases
                        nxt_tgt = VOLT_RST;
                        if (trip_event_clear && !group_trip) begin
                            nxt_st  = ST_NORMAL;
                            nxt_tgt = vset[gi];
                        end
                    end
                    default: begin
                        nxt_st = ST_NORMAL;
                    end
                endcase
                // group shutdown overrides; no jump, so the ramp-down
                // starts from whatever lowered value is in the DAC
                if (group_trip) begin
                    nxt_st  = ST_TRIPPED;
                    nxt_tgt = VOLT_RST;
                    jump    = 1'b0;
                    floor_set = 1'b0;
                end
            end

            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    st_ff   <= ST_NORMAL;
                    cnt_ff  <= MAX_DELAY_MS;
                    ccms_ff <= '0;
                    tgt_ff  <= VOLT_RST;
                end else begin
                    st_ff   <= nxt_st;
                    cnt_ff  <= nxt_cnt;
                    ccms_ff <= nxt_ccms;
                    tgt_ff  <= nxt_tgt;
                end
            end

            // flags: hardware set wins over a same-cycle clear
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    floor_ev_ff[gi] <= 1'b0;
                end else if (floor_set) begin
                    floor_ev_ff[gi] <= 1'b1;
                end else if (floor_event_clear[gi]) begin
                    floor_ev_ff[gi] <= 1'b0;
                end
            end

            // only a reading taken during this limit spell counts as fresh
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    vm_new_ff <= 1'b0;
                end else if (vmeas_valid[gi] && in_limit) begin
                    vm_new_ff <= 1'b1;
                end else if (vm_used || !in_limit) begin
                    vm_new_ff <= 1'b0;
                end
            end

            // follows the next state so it rises with the floor jump
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    clamp_ff[gi] <= 1'b0;
                end else begin
                    clamp_ff[gi] <= (nxt_st == ST_LIMIT);
                end
            end

            assign rp.target     = tgt_ff;
            assign rp.step       = ramp_step[gi];
            assign rp.jump       = jump;
            assign rp.jump_value = jump_val;

            setpoint_ramp u_ramp (
                .clk_sys (clk_sys),
                .srst    (srst),
                .tick    (tick),
                .rp      (rp.ramp_side)
            );

            assign vsetint[gi] = rp.value;
        end
    endgenerate

    assign current_clamp       = clamp_ff;
    assign floor_reached_event = floor_ev_ff;
    assign trip_event          = trip_ev_ff;
endmodule : delayed_trip_floor_voltage_ctrl

/* File: tb/trip_floor_properties.sv */
// port-level assertions for the delayed trip / floor sequencer
module trip_floor_properties
    import trip_floor_pkg::*;
#(
    parameter int TICK_CYCLES_P = 20000
) (
    input wire logic                              clk_sys,
    input wire logic                              srst,
    input wire logic [trip_floor_pkg::NUM_CH-1:0] current_limit_regulation,
    input wire logic [trip_floor_pkg::NUM_CH-1:0] fast_overcurrent_shutdown,
    input wire logic [trip_floor_pkg::NUM_CH-1:0] floor_event_clear,
    input wire logic                              trip_event_clear,
    input wire trip_floor_pkg::volt_t             vsetint [trip_floor_pkg::NUM_CH],
    input wire logic [trip_floor_pkg::NUM_CH-1:0] current_clamp,
    input wire logic [trip_floor_pkg::NUM_CH-1:0] floor_reached_event,
    input wire logic                              trip_event
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_reset_clears_all: assert property ($past(srst) |-> !trip_event
        && floor_reached_event == '0 && current_clamp == '0
        && vsetint[0] == VOLT_RST) else $error("state not cleared by reset");
    a_trip_stays_set: assert property (trip_event && !trip_event_clear
        |=> trip_event) else $error("trip event lost without clear");
    a_floor_flag_sticky: assert property (($past(floor_reached_event)
        & ~$past(floor_event_clear) & ~floor_reached_event) == '0)
        else $error("floor event lost without clear");
    a_trip_drops_clamp: assert property ($rose(trip_event)
        |-> current_clamp == '0) else $error("clamp kept after trip");
    a_trip_needs_limit: assert property ($rose(trip_event)
        |-> ($past(current_limit_regulation, 3)
        & ~$past(fast_overcurrent_shutdown, 3)) != '0)
        else $error("trip without unshielded current limit");
    a_clamp_needs_limit: assert property ((current_clamp
        & ~$past(current_clamp) & ~$past(current_limit_regulation, 3)) == '0)
        else $error("clamp raised without current limit");
    a_floor_with_clamp: assert property ((floor_reached_event
        & ~$past(floor_reached_event) & ~current_clamp) == '0)
        else $error("floor event without countdown");
    a_group_ramp_down: assert property (trip_event && $past(trip_event)
        |-> vsetint[0] <= $past(vsetint[0]))
        else $error("setpoint rose while tripped");
    a_one_step_tick: assert property (vsetint[0] != $past(vsetint[0])
        |=> $stable(vsetint[0]) [*8]) else $error("setpoint moved twice");
endmodule : trip_floor_properties

bind delayed_trip_floor_voltage_ctrl trip_floor_properties #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
) chk (
    .clk_sys(clk_sys), .srst(srst),
    .current_limit_regulation(current_limit_regulation),
    .fast_overcurrent_shutdown(fast_overcurrent_shutdown),
    .floor_event_clear(floor_event_clear),
    .trip_event_clear(trip_event_clear), .vsetint(vsetint),
    .current_clamp(current_clamp), .floor_reached_event(floor_reached_event),
    .trip_event(trip_event)
);

/* File: tb/hv_regulator_model.sv */
// behavioural high-voltage regulator facing the sequencer
module hv_regulator_model
    import trip_floor_pkg::*;
#(
    parameter int MEAS_CYC = 100
) (
    input  wire logic                              clk_sys,
    input  wire trip_floor_pkg::volt_t             vsetint [trip_floor_pkg::NUM_CH],
    input  wire logic [trip_floor_pkg::NUM_CH-1:0] discharge,
    input  wire trip_floor_pkg::volt_t             vcc [trip_floor_pkg::NUM_CH],
    output logic [trip_floor_pkg::NUM_CH-1:0]      voltage_regulation,
    output logic [trip_floor_pkg::NUM_CH-1:0]      current_limit_regulation,
    output trip_floor_pkg::volt_t                  vmeas [trip_floor_pkg::NUM_CH],
    output logic [trip_floor_pkg::NUM_CH-1:0]      vmeas_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic lim;

    initial begin
        voltage_regulation = '1;
        current_limit_regulation = '0;
        vmeas_valid = '0;
        foreach (vmeas[i]) vmeas[i] = '0;
    end
    // a discharging load only limits while the setpoint sits above its knee
    always @(negedge clk_sys) begin
        cnt <= (cnt == MEAS_CYC - 1) ? 0 : cnt + 1;
        for (int i = 0; i < NUM_CH; i++) begin
            lim = discharge[i] && vsetint[i] > vcc[i];
            current_limit_regulation[i] <= lim;
            voltage_regulation[i] <= !lim;
            vmeas[i] <= lim ? vcc[i] : vsetint[i];
            vmeas_valid[i] <= (cnt == 0);
        end
    end
endmodule : hv_regulator_model

/* File: tb/delayed_trip_floor_voltage_ctrl_test.sv */
// self-checking bench for the delayed trip / floor sequencer
module delayed_trip_floor_voltage_ctrl_test
    import trip_floor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 20;
    logic              clk_sys = 0;
    logic              srst = 1;
    logic              tclr = 0;
    logic              trip;
    logic [NUM_CH-1:0] cvr, ccr, vvalid, clamp, fev;
    logic [NUM_CH-1:0] fos = '0;
    logic [NUM_CH-1:0] fclr = '0;
    logic [NUM_CH-1:0] dis = '0;
    volt_t             vmeas [NUM_CH];
    volt_t             vset [NUM_CH];
    volt_t             step [NUM_CH];
    volt_t             vcc [NUM_CH];
    volt_t             vsi [NUM_CH];
    logic [DELAY_W-1:0] dly [NUM_CH];
    logic [PCT_W-1:0]  pct [NUM_CH];
    int                exp_v [NUM_CH];
    int                fail_count = 0;
    int                num_checks = 0;
    int                seed = 36714;

    delayed_trip_floor_voltage_ctrl #(.TICK_CYCLES_P(TK)) dut (
        .clk_sys(clk_sys), .srst(srst), .voltage_regulation(cvr),
        .current_limit_regulation(ccr), .vmeas(vmeas), .vmeas_valid(vvalid),
        .vset(vset), .ramp_step(step), .trip_delay_ms(dly),
        .floor_pct(pct), .fast_overcurrent_shutdown(fos),
        .floor_event_clear(fclr), .trip_event_clear(tclr), .vsetint(vsi),
        .current_clamp(clamp), .floor_reached_event(fev), .trip_event(trip)
    );
    hv_regulator_model #(.MEAS_CYC(100)) plant (
        .clk_sys(clk_sys), .vsetint(vsi), .discharge(dis), .vcc(vcc),
        .voltage_regulation(cvr), .current_limit_regulation(ccr),
        .vmeas(vmeas), .vmeas_valid(vvalid)
    );

    task automatic chk(string what, int e, logic [15:0] got);
        num_checks++;
        if (got !== 16'(e)) begin
            fail_count++;
            $display("[ERR] %s expected %0d seen %0d", what, e, got);
        end
    endtask : chk
    task automatic chk_all();
        for (int i = 0; i < NUM_CH; i++) chk($sformatf("vsetint%0d", i),
            exp_v[i], vsi[i]);
    endtask : chk_all
    task automatic ticks(int n);
        repeat (n * TK) @(negedge clk_sys);
    endtask : ticks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // full run is about 12000 cycles
    initial begin
        #(16000 * 50);
        fail_count++;
        wrap_up();
    end

    initial begin
        for (int i = 0; i < NUM_CH; i++) begin
            vset[i] = 16'(100 * (4 + ($random(seed) & 7)));
            vcc[i] = 16'(vset[i] * 3 / 4);
            step[i] = 16'h0064;
            dly[i] = 12'hFA0;
            pct[i] = 7'h64;
            exp_v[i] = vset[i];
        end
        pct[0] = 7'h32;
        pct[1] = 7'h5A;
        pct[2] = 7'h00;
        dly[4] = 12'h005;
        dly[5] = 12'h005;
        fos[5] = 1'b1;
        repeat (20) @(negedge clk_sys);
        srst = 0;
        @(negedge clk_sys);
        chk("trip_event", 0, 16'(trip));
        chk("flags", 0, {fev, clamp});
        repeat (9) @(negedge clk_sys);
        ticks(15);
        chk_all();
        // floor below, above the knee, zero and full floor in one go
        dis = 8'h0F;
        exp_v[0] = vset[0] / 2;
        exp_v[1] = vset[1] * 90 / 100;
        exp_v[2] = 0;
        ticks(2);
        chk_all();
        chk("floor_reached_event", 'h07, 16'(fev));
        chk("current_clamp", 'h0A, 16'(clamp));
        ticks(10);
        chk_all();
        dis = 8'h00;
        ticks(2);
        chk_all();
        chk("current_clamp", 0, 16'(clamp));
        fclr = 8'h07;
        @(negedge clk_sys);
        fclr = 8'h00;
        for (int i = 0; i < 3; i++) exp_v[i] = vset[i];
        ticks(13);
        chk("floor_reached_event", 0, 16'(fev));
        chk_all();
        // long current limit lowers the setpoint above the measurement
        dis = 8'h40;
        ticks(495);
        chk_all();
        ticks(15);
        exp_v[6] = vcc[6] + 16;
        chk_all();
        dis = 8'h00;
        exp_v[6] = vset[6];
        ticks(6);
        chk_all();
        dis = 8'h30;
        ticks(3);
        dis = 8'h20;
        ticks(2);
        dis = 8'h30;
        ticks(4);
        chk("trip_event", 0, 16'(trip));
        chk("current_clamp", 'h10, 16'(clamp));
        ticks(1);
        chk("trip_event", 1, 16'(trip));
        for (int i = 0; i < NUM_CH; i++) exp_v[i] = 0;
        ticks(15);
        chk_all();
        chk("trip_event", 1, 16'(trip));
        tclr = 1;
        @(negedge clk_sys);
        tclr = 0;
        @(negedge clk_sys);
        chk("trip_event", 0, 16'(trip));
        wrap_up();
    end
endmodule : delayed_trip_floor_voltage_ctrl_test
